//--- rtl/scr_regs.sv
// Notes on behaviour
// - a 0-to-1 change of the calibration trigger bit starts a calibration when the sequencer is idle; a low bit leaves it idle.
// - results go to the set picked by the frequency select input, or to both sets when the dual option is 1.
// - the duration code picks 90000, 110000, 130000 or 200000 reference periods of calibration.
// - the DAC seed field gives a DAC start value of field plus one, 1 to 8, and resets to 5.
// - the upper amplifier nibble sets the strong array, 0 off, 15 maximum, reset 0.
// - the lower amplifier nibble sets the weak array, 0 off, 15 maximum, reset 15.
// - the upper matching nibble selects the receive capacitor array, reset 0.
// - the lower matching nibble selects the transmit capacitor array, reset 0.
// - the phase trim is a signed byte passed on unchanged as a two's complement code.
// - the gain trim is a signed byte passed on unchanged as a two's complement code.
// - calibration time is counted in periods of the synthesizer reference clock.
//
// Chosen here: register access over APB.
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module scr_regs
    import scr_pkg::*;
#(
    parameter int CAL_REF_C0 = `SCR_CAL_REF_C0,
    parameter int CAL_REF_C1 = `SCR_CAL_REF_C1,
    parameter int CAL_REF_C2 = `SCR_CAL_REF_C2,
    parameter int CAL_REF_C3 = `SCR_CAL_REF_C3
) (
    input  wire logic                   pclk,          // bus clock
    input  wire logic                   presetn,       // async reset, low
    input  wire logic                   psel,          // apb select
    input  wire logic                   penable,       // apb access phase
    input  wire logic                   pwrite,        // apb direction
    input  wire logic [`SCR_ADDR_W-1:0] paddr,         // apb byte address
    input  wire logic [31:0]            pwdata,        // apb write data
    input  wire logic [3:0]             pstrb,         // apb byte strobes
    output logic      [31:0]            prdata,        // apb read data
    output logic                        pready,        // apb ready
    output logic                        pslverr,       // apb error
    input  wire logic                   ref_tick,      // reference period
    input  wire logic                   freq_sel,      // set b when high
    output logic                        cal_busy,      // calibrating
    output logic                        cal_store_a,   // store to set a
    output logic                        cal_store_b,   // store to set b
    output logic      [3:0]             cal_dac_start, // dac start 1..8
    output scr_amp_t                    amp_level,     // array levels
    output scr_match_t                  match_trim,    // matching caps
    output logic      [7:0]             phase_trim,    // signed phase
    output logic      [7:0]             gain_trim      // signed gain
);

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [`SCR_CNT_W-1:0] cal_limit(
        input logic [1:0] code
    );
        logic [`SCR_CNT_W-1:0] r;
        r = '0;
        unique case (code)
            2'h0: r = `SCR_CNT_W'(CAL_REF_C0);
            2'h1: r = `SCR_CNT_W'(CAL_REF_C1);
            2'h2: r = `SCR_CNT_W'(CAL_REF_C2);
            2'h3: r = `SCR_CNT_W'(CAL_REF_C3);
        endcase
        return r;
    endfunction

    function automatic logic [3:0] dac_start(input logic [2:0] seed);
        return {1'b0, seed} + 4'h1;
    endfunction

    // ****************************************************************
    // bus decode
    // ****************************************************************
    scr_calib_t            calib_q;
    scr_amp_t              amp_q;
    scr_match_t            match_q;
    logic [7:0]            phase_q;
    logic [7:0]            gain_q;
    scr_cal_state_t        state_q;
    logic [`SCR_CNT_W-1:0] cnt_q;
    logic                  store_a_q;
    logic                  store_b_q;
    logic [31:0]           rdata_d;
    logic                  mapped;
    logic                  wr_en;
    logic [7:0]            idx;
    logic                  trig_rise;
    scr_calib_t            wr_calib;
    logic [`SCR_CNT_W-1:0] limit_q;
    logic                  at_limit;

    assign idx   = paddr[9:2];
    assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;

    always_comb begin
        mapped  = 1'b1;
        rdata_d = 32'h0;
        unique case (idx)
            `SCR_IDX_CALIB:  rdata_d[7:0] = {calib_q[7:4], 1'b0,
                                             calib_q[2:0]};
            `SCR_IDX_AMP:    rdata_d[7:0] = amp_q;
            `SCR_IDX_MATCH:  rdata_d[7:0] = match_q;
            `SCR_IDX_PHASE:  rdata_d[7:0] = phase_q;
            `SCR_IDX_GAIN:   rdata_d[7:0] = gain_q;
            // read-only sequencer state, for software polling
            `SCR_IDX_STATUS: rdata_d[1:0] = state_q;
            default:         mapped       = 1'b0;
        endcase
        if (paddr[`SCR_ADDR_W-1:10] != '0) begin
            mapped  = 1'b0;
            rdata_d = 32'h0;
        end
    end

    // zero wait states keep every access to exactly two cycles
    assign pready  = 1'b1;
    // a refused access still completes, it only flags the error
    assign pslverr = psel && penable && !mapped;

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    // ****************************************************************
    // register storage
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calib_q <= `SCR_RST_CALIB;
        end else if (wr_en && idx == `SCR_IDX_CALIB) begin
            // reserved bit kept low whatever is written
            calib_q <= {pwdata[7:4], 1'b0, pwdata[2:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_q <= `SCR_RST_AMP;
        end else if (wr_en && idx == `SCR_IDX_AMP) begin
            amp_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= `SCR_RST_MATCH;
        end else if (wr_en && idx == `SCR_IDX_MATCH) begin
            match_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= `SCR_RST_PHASE;
            gain_q  <= `SCR_RST_GAIN;
        end else if (wr_en) begin
            if (idx == `SCR_IDX_PHASE) begin
                phase_q <= pwdata[7:0];
            end
            if (idx == `SCR_IDX_GAIN) begin
                gain_q <= pwdata[7:0];
            end
        end
    end

    // ****************************************************************
    // calibration sequencer
    // ****************************************************************
    // only a written 0-to-1 change counts; a repeated 1 is no edge
    assign trig_rise = wr_en && idx == `SCR_IDX_CALIB && pwdata[7]
                       && !calib_q.start;
    assign wr_calib  = pwdata[7:0];
    assign at_limit  = cnt_q == limit_q;

    // duration frozen at start: a rewrite mid-run could drop the limit
    // below the count and let the counter wrap round
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_q <= '0;
        end else if (state_q == SCR_IDLE && trig_rise) begin
            limit_q <= cal_limit(wr_calib.wait_sel);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SCR_IDLE;
        end else begin
            // a trigger during run or store is dropped, not queued
            unique case (state_q)
                SCR_IDLE: if (trig_rise) begin
                    state_q <= SCR_RUN;
                end
                SCR_RUN: if (at_limit) begin
                    state_q <= SCR_STORE;
                end
                SCR_STORE: state_q <= SCR_IDLE;
                default:   state_q <= SCR_IDLE;
            endcase
        end
    end

    // counts reference periods, not bus cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (state_q != SCR_RUN) begin
            cnt_q <= '0;
        end else if (ref_tick) begin
            cnt_q <= cnt_q + `SCR_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_a_q <= 1'b0;
            store_b_q <= 1'b0;
        end else begin
            // set select and dual option taken at the last run cycle
            store_a_q <= state_q == SCR_RUN
                         && at_limit
                         && (calib_q.dual || !freq_sel);
            store_b_q <= state_q == SCR_RUN
                         && at_limit
                         && (calib_q.dual || freq_sel);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cal_busy      = state_q != SCR_IDLE;
    assign cal_store_a   = store_a_q;
    assign cal_store_b   = store_b_q;
    assign cal_dac_start = dac_start(calib_q.seed);
    assign amp_level     = amp_q;
    assign match_trim    = match_q;
    assign phase_trim    = phase_q;
    assign gain_trim     = gain_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // a write that really lands in a register
    sequence s_wr(logic [7:0] at);
        psel && penable && pwrite && pstrb[0] && mapped && idx == at;
    endsequence

    sequence s_done;
        state_q == SCR_RUN && at_limit;
    endsequence

    AST_CAL_START: assert property (
        state_q == SCR_IDLE && trig_rise |=> state_q == SCR_RUN)
        else $error("calibration did not start on trigger edge");

    AST_NO_RETRIG: assert property (
        (state_q == SCR_IDLE && calib_q.start) and s_wr(`SCR_IDX_CALIB)
        |=> state_q == SCR_IDLE)
        else $error("rewritten trigger restarted calibration");

    AST_STORE_ONE: assert property (
        s_done and !calib_q.dual
        |=> cal_store_a == !$past(freq_sel) && cal_store_b == $past(freq_sel))
        else $error("results stored to wrong set");

    AST_STORE_BOTH: assert property (
        s_done and calib_q.dual |=> cal_store_a && cal_store_b)
        else $error("dual store missed a set");

    AST_DURATION: assert property (
        state_q == SCR_RUN |-> cnt_q <= limit_q)
        else $error("calibration overran its duration");

    AST_DONE_STORE: assert property (
        s_done |=> state_q == SCR_STORE ##1 state_q == SCR_IDLE)
        else $error("calibration did not end after its duration");

    AST_REF_COUNT: assert property (
        state_q == SCR_RUN && !ref_tick && !at_limit
        |=> $stable(cnt_q))
        else $error("counter moved without a reference period");

    AST_DAC_SEED: assert property (
        cal_dac_start == {1'b0, calib_q.seed} + 4'h1
        && cal_dac_start >= 4'h1 && cal_dac_start <= 4'h8)
        else $error("dac start value out of step with seed");

    AST_AMP_WR: assert property (
        s_wr(`SCR_IDX_AMP) |=> amp_level.strong_array_level
        == $past(pwdata[7:4]) && amp_level.weak_array_level
        == $past(pwdata[3:0]))
        else $error("amplifier levels not updated by write");

    AST_MATCH_WR: assert property (
        s_wr(`SCR_IDX_MATCH) |=> match_trim.rx_cap == $past(pwdata[7:4])
        && match_trim.tx_cap == $past(pwdata[3:0]))
        else $error("matching trims not updated by write");

    AST_TRIM_WR: assert property (
        s_wr(`SCR_IDX_PHASE) |=> phase_trim == $past(pwdata[7:0]))
        else $error("phase trim not updated by write");

    AST_GAIN_WR: assert property (
        s_wr(`SCR_IDX_GAIN) |=> gain_trim == $past(pwdata[7:0]))
        else $error("gain trim not updated by write");

    AST_IDLE_STAY: assert property (
        state_q == SCR_IDLE && !trig_rise |=> state_q == SCR_IDLE)
        else $error("calibration started without trigger edge");

    AST_NO_EARLY_END: assert property (
        state_q == SCR_RUN && !at_limit |=> state_q == SCR_RUN)
        else $error("calibration ended before its duration");

    AST_WAIT_LOADED: assert property (
        state_q == SCR_IDLE && trig_rise
        |=> limit_q == cal_limit($past(wr_calib.wait_sel)))
        else $error("duration not taken from the trigger write");

    AST_STORE_PULSE: assert property (
        cal_store_a || cal_store_b |=> !cal_store_a && !cal_store_b)
        else $error("store pulse longer than one cycle");

    AST_STRB_IGNORE: assert property (
        psel && penable && pwrite && !pstrb[0]
        |=> $stable(amp_level) && $stable(match_trim)
        && $stable(phase_trim) && $stable(gain_trim))
        else $error("write without byte strobe changed a register");

endmodule // scr_regs

`default_nettype wire

//--- rtl/scr_cfg.svh
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// ********************************************************************
// register indices (byte address = index * 4)
// ********************************************************************
`define SCR_ADDR_W        12
`define SCR_IDX_CALIB     8'h1b
`define SCR_IDX_AMP       8'h1c
`define SCR_IDX_MATCH     8'h1d
`define SCR_IDX_PHASE     8'h1e
`define SCR_IDX_GAIN      8'h1f
`define SCR_IDX_STATUS    8'h3f

// ********************************************************************
// reset values
// ********************************************************************
`define SCR_RST_CALIB     8'h05
`define SCR_RST_AMP       8'h0f
`define SCR_RST_MATCH     8'h00
`define SCR_RST_PHASE     8'h00
`define SCR_RST_GAIN      8'h00

// ********************************************************************
// calibration time in reference periods, per duration code
// ********************************************************************
`define SCR_CAL_REF_C0    90000
`define SCR_CAL_REF_C1    110000
`define SCR_CAL_REF_C2    130000
`define SCR_CAL_REF_C3    200000
`define SCR_CNT_W         18

`endif

//--- rtl/scr_pkg.sv
package scr_pkg;

    // calibration control byte as laid out in the register
    typedef struct packed {
        logic       start;
        logic       dual;
        logic [1:0] wait_sel;
        logic       rsvd;
        logic [2:0] seed;
    } scr_calib_t;

    typedef struct packed {
        logic [3:0] strong_array_level;
        logic [3:0] weak_array_level;
    } scr_amp_t;

    typedef struct packed {
        logic [3:0] rx_cap;
        logic [3:0] tx_cap;
    } scr_match_t;

    typedef enum logic [1:0] {
        SCR_IDLE  = 2'b00,
        SCR_RUN   = 2'b01,
        SCR_STORE = 2'b11
    } scr_cal_state_t;

endpackage

//--- dv/scr_host.sv
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// ********************************************************************
// host side: apb master driving the configuration registers
// ********************************************************************
module scr_host (
    input  wire logic                   pclk,    // bus clock
    output logic                        psel,    // apb select
    output logic                        penable, // apb access phase
    output logic                        pwrite,  // apb direction
    output logic      [`SCR_ADDR_W-1:0] paddr,   // apb byte address
    output logic      [31:0]            pwdata,  // apb write data
    output logic      [3:0]             pstrb,   // apb byte strobes
    input  wire logic [31:0]            prdata,  // apb read data
    input  wire logic                   pready,  // apb ready
    input  wire logic                   pslverr  // apb error
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        // reserved calibration bit always sent as zero
        pwdata  <= (idx == `SCR_IDX_CALIB) ? (d & ~32'h8) : d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        pwdata  <= ~pwdata;
        paddr   <= ~paddr;
    endtask
endmodule // scr_host

`default_nettype wire

//--- dv/synth_calibration_and_rf_trim_regs_tb.sv
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module synth_calibration_and_rf_trim_regs_tb
    import scr_pkg::*;
;
    localparam int L0 = 4;
    localparam int L1 = 5;
    localparam int L2 = 6;
    localparam int L3 = 8;

    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   ref_tick = 1'b0;
    logic                   freq_sel = 1'b0;
    logic                   psel, penable, pwrite, pready, pslverr;
    logic [`SCR_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata;
    logic [3:0]             pstrb, cal_dac_start;
    logic                   cal_busy, cal_store_a, cal_store_b;
    scr_amp_t               amp_level;
    scr_match_t             match_trim;
    logic [7:0]             phase_trim, gain_trim;
    int                     num_errors = 0;
    int                     num_checks = 0;
    integer                 seed = 76826;
    logic [31:0]            r;

    scr_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    scr_regs #(.CAL_REF_C0(L0), .CAL_REF_C1(L1), .CAL_REF_C2(L2),
        .CAL_REF_C3(L3)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_tick(ref_tick),
        .freq_sel(freq_sel), .cal_busy(cal_busy),
        .cal_store_a(cal_store_a), .cal_store_b(cal_store_b),
        .cal_dac_start(cal_dac_start), .amp_level(amp_level),
        .match_trim(match_trim), .phase_trim(phase_trim),
        .gain_trim(gain_trim));

    always #5 pclk = ~pclk;

    // never two ticks in a row, so the tick count at the end is exact
    always @(posedge pclk) ref_tick <= !ref_tick && (($random(seed) & 3) != 0);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic int lim(input logic [1:0] code);
        return (code == 2'd0) ? L0 : (code == 2'd1) ? L1 :
               (code == 2'd2) ? L2 : L3;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] rd;
        logic        err;
        host.xfer(1'b1, idx, d, s, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                          input logic experr);
        logic [31:0] rd;
        logic        err;
        host.xfer(1'b0, idx, 32'h0, 4'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, experr});
    endtask

    task automatic run_cal(input logic [1:0] code, input logic dual);
        int   ticks;
        logic fs;
        r = $random(seed);
        fs = r[0];
        freq_sel <= fs;
        wr(`SCR_IDX_CALIB, {24'h0, 1'b0, dual, code, 4'h4}, 4'hf);
        #1 check({31'h0, cal_busy}, 32'h0);
        wr(`SCR_IDX_CALIB, {24'h0, 1'b1, dual, code, 4'h4}, 4'hf);
        ticks = 0;
        // look just after each edge: ref_tick then shows the value that
        // the design samples at the next edge, the first one included
        #1;
        for (int n = 0; n < 300; n++) begin
            if (cal_store_a || cal_store_b) break;
            if (cal_busy && ref_tick) ticks++;
            @(posedge pclk);
            #1;
        end
        check(ticks, lim(code));
        check({30'h0, cal_store_a, cal_store_b},
              dual ? 32'h3 : (fs ? 32'h1 : 32'h2));
        @(posedge pclk);
        #1 check({31'h0, cal_busy}, 32'h0);
        wr(`SCR_IDX_CALIB, {24'h0, 1'b1, dual, code, 4'h4}, 4'hf);
        repeat (3) @(posedge pclk);
        #1 check({31'h0, cal_busy}, 32'h0);
        rd_chk(`SCR_IDX_CALIB, {24'h0, 1'b1, dual, code, 4'h4}, 1'b0);
    endtask

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check({28'h0, cal_dac_start}, 32'h6);
        check({24'h0, amp_level}, 32'h0f);
        rd_chk(`SCR_IDX_CALIB, 32'h05, 1'b0);
        rd_chk(`SCR_IDX_AMP, 32'h0f, 1'b0);
        rd_chk(`SCR_IDX_MATCH, 32'h00, 1'b0);
        rd_chk(`SCR_IDX_PHASE, 32'h00, 1'b0);
        rd_chk(`SCR_IDX_GAIN, 32'h00, 1'b0);
        rd_chk(`SCR_IDX_STATUS, 32'h0, 1'b0);
        for (int s = 0; s < 8; s++) begin
            wr(`SCR_IDX_CALIB, s, 4'hf);
            #1 check({28'h0, cal_dac_start}, s + 1);
            rd_chk(`SCR_IDX_CALIB, s, 1'b0);
        end
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 32'h7f80ff0f : $random(seed);
            // host drives one array at a time to save current
            r[7:0] = i[0] ? {r[3:0], 4'h0} : {4'h0, r[3:0]};
            wr(`SCR_IDX_AMP, r[7:0], 4'hf);
            wr(`SCR_IDX_MATCH, r[15:8], 4'hf);
            wr(`SCR_IDX_PHASE, r[23:16], 4'hf);
            wr(`SCR_IDX_GAIN, r[31:24], 4'hf);
            wr(`SCR_IDX_PHASE, ~r[23:16], 4'he);
            #1 check({24'h0, amp_level}, r[7:0]);
            check({24'h0, match_trim}, r[15:8]);
            check({24'h0, phase_trim}, r[23:16]);
            check({24'h0, gain_trim}, r[31:24]);
            rd_chk(`SCR_IDX_MATCH, r[15:8], 1'b0);
            rd_chk(`SCR_IDX_GAIN, r[31:24], 1'b0);
        end
        rd_chk(8'h20, 32'h0, 1'b1);
        // duration code 3 is the recommended setting, run last
        for (int c = 0; c < 4; c++) run_cal(c[1:0], c[0]);
        run_cal(2'd3, 1'b0);
        // reset in mid-calibration must bring everything back to defaults
        wr(`SCR_IDX_CALIB, 32'h34, 4'hf);
        wr(`SCR_IDX_CALIB, 32'hb4, 4'hf);
        rd_chk(`SCR_IDX_STATUS, 32'h1, 1'b0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        #1 check({31'h0, cal_busy}, 32'h0);
        check({24'h0, amp_level}, 32'h0f);
        rd_chk(`SCR_IDX_CALIB, 32'h05, 1'b0);
        print_verdict();
    end

    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
endmodule // synth_calibration_and_rf_trim_regs_tb

`default_nettype wire
